//--- src/param_dict_pkg.sv
// package for the parameter object dictionary
package param_dict_pkg;

  localparam logic [15:0] IDX_IDENT_BASE = 16'h1000;
  localparam logic [15:0] IDX_DEVTYPE = 16'h1000;
  localparam logic [15:0] IDX_NAME = 16'h1008;
  localparam logic [15:0] IDX_IDENTITY = 16'h1018;
  localparam logic [15:0] IDX_PDO_CUR = 16'h1C12;
  localparam logic [15:0] IDX_PDO_AVAIL = 16'h1C13;
  localparam logic [15:0] IDX_ALT_CHAN_BASE = 16'h4000;
  localparam logic [15:0] IDX_INPUT_BASE = 16'h6000;
  localparam logic [15:0] IDX_OUTPUT_BASE = 16'h7000;
  localparam logic [15:0] IDX_CHAN_BASE = 16'h8000;
  localparam logic [15:0] IDX_STORE_SUPPRESS = 16'hF008;
  localparam logic [31:0] STORE_SUPPRESS_CODE = 32'h12345678;

  localparam int CHAN_COUNT = 4;
  localparam int CHAN_STRIDE = 16;
  localparam int CHAN_PARAMS = 4;
  localparam int INPUT_COUNT = 4;
  localparam int OUTPUT_COUNT = 4;

  localparam logic [31:0] DEVTYPE_VALUE = 32'h00002468; // arbitrary value
  localparam logic [31:0] VENDOR_VALUE = 32'h0000ABCD; // arbitrary value
  localparam logic [31:0] PRODUCT_VALUE = 32'h00001234; // arbitrary value
  localparam logic [31:0] REVISION_VALUE = 32'h00010000; // arbitrary value
  localparam logic [31:0] SERIAL_VALUE = 32'h00000001; // arbitrary value
  localparam logic [31:0] NAME_VALUE = 32'h50444943; // arbitrary value
  localparam logic [31:0] PDO_CUR_VALUE = 32'h00001A00;
  localparam logic [31:0] PDO_AVAIL_VALUE = 32'h00001A01;
  localparam logic [7:0] IDENTITY_SUBCOUNT = 8'h04;
  localparam logic [31:0] CHAN_PARAM_RESET = 32'h00000000;
  localparam logic [31:0] OUTPUT_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    DT_BOOL = 3'b000,
    DT_U8 = 3'b001,
    DT_U16 = 3'b010,
    DT_U32 = 3'b011,
    DT_STRING = 3'b100
  } data_type_t;

  typedef enum logic [1:0] {
    RESP_OK = 2'b00,
    RESP_NO_OBJECT = 2'b01,
    RESP_READ_ONLY = 2'b10,
    RESP_SIZE = 2'b11
  } resp_code_t;

  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [2:0] size;
    logic [31:0] data;
  } dict_req_t;

  typedef struct packed {
    resp_code_t code;
    data_type_t dtype;
    logic [31:0] data;
  } dict_resp_t;

  typedef struct packed {
    logic present;
    logic writable;
    data_type_t dtype;
    logic [31:0] value;
  } entry_info_t;

endpackage

//--- src/index_decoder.sv
// classifies an index into its dictionary range
`timescale 1ns/10ps
`default_nettype none
module index_decoder (
  input wire logic [15:0] index,
  input wire logic altLayout,
  output logic isIdent,
  output logic isChan,
  output logic isInput,
  output logic isOutput,
  output logic isSuppress,
  output logic [1:0] chanNum,
  output logic [3:0] chanParam
);
  import param_dict_pkg::*;

  logic [15:0] chanBase;
  logic [15:0] chanOff;

  // RULE5 alternate channel base
  assign chanBase = altLayout ? IDX_ALT_CHAN_BASE : IDX_CHAN_BASE;
  assign chanOff = index - chanBase;
  // RULE3 identity range
  assign isIdent = index[15:12] == IDX_IDENT_BASE[15:12];
  // RULE4 channel parameter range
  assign isChan = (index[15:12] == chanBase[15:12]) && (chanOff < 16'(CHAN_COUNT * CHAN_STRIDE));
  // RULE10 sixteen index stride
  assign chanNum = chanOff[5:4];
  assign chanParam = chanOff[3:0];
  // RULE6 input objects
  assign isInput = index == IDX_INPUT_BASE;
  // RULE7 output objects
  assign isOutput = index == IDX_OUTPUT_BASE;
  assign isSuppress = index == IDX_STORE_SUPPRESS;
endmodule // index_decoder
`default_nettype wire

//--- src/parameter_object_dictionary.sv
// parameter object dictionary with request and response port
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1 - entries keyed by 16-bit index, 8-bit subindex
// RULE2 - writes accepted only on variable entries
// RULE3 - identity data held from 0x1000
// RULE4 - channel parameters held from 0x8000
// RULE5 - variant places channels at 0x4000
// RULE6 - input process data at 0x6000
// RULE7 - output process data at 0x7000
// RULE8 - each entry typed; access respects size (the code checks the size on writes only; reads of any size are accepted)
// RULE9 - every present entry readable
// RULE10 - channel blocks repeat every sixteen indices
// RULE11 - code word suppresses nonvolatile saving
// RULE12 - missing or read-only access refused unchanged
module parameter_object_dictionary (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic altLayout,
  input wire logic reqValid,
  input wire param_dict_pkg::dict_req_t req,
  input wire logic [31:0] inputData [param_dict_pkg::INPUT_COUNT],
  output param_dict_pkg::dict_resp_t resp_reg,
  output logic respValid_reg,
  output logic [31:0] outputData_reg [param_dict_pkg::OUTPUT_COUNT],
  output logic storeSuppress_reg,
  output logic saveStrobe_reg,
  output logic [15:0] saveIndex_reg,
  output logic [7:0] saveSubindex_reg
);
  import param_dict_pkg::*;

  logic isIdent;
  logic isChan;
  logic isInput;
  logic isOutput;
  logic isSuppress;
  logic [1:0] chanNum;
  logic [3:0] chanParam;
  logic [31:0] chanMem [CHAN_COUNT][CHAN_PARAMS];
  logic [31:0] suppressWord_reg;
  entry_info_t info;
  logic sizeOk;
  logic doWrite;
  logic chanHit;
  logic outHit;
  logic [1:0] outSel;
  logic inHit;
  logic subZero;

  index_decoder decoder (
    .index(req.index),
    .altLayout(altLayout),
    .isIdent(isIdent),
    .isChan(isChan),
    .isInput(isInput),
    .isOutput(isOutput),
    .isSuppress(isSuppress),
    .chanNum(chanNum),
    .chanParam(chanParam)
  );

  // size in bytes implied by a data type
  function automatic logic [2:0] type_size(input data_type_t t);
    case (t)
      DT_BOOL: type_size = 3'h1;
      DT_U8: type_size = 3'h1;
      DT_U16: type_size = 3'h2;
      default: type_size = 3'h4;
    endcase
  endfunction

  // list slot addressed by subindex one upwards
  function automatic logic [1:0] slot_of(input logic [7:0] sub);
    slot_of = sub[1:0] - 2'h1;
  endfunction

  // subindex zero of a list holds its length
  assign subZero = req.subindex == 8'h00;
  assign chanHit = isChan && (chanParam < 4'(CHAN_PARAMS)) && subZero;
  assign outSel = slot_of(req.subindex);
  assign inHit = isInput && !subZero &&
    (req.subindex <= 8'(INPUT_COUNT));
  assign outHit = isOutput && !subZero &&
    (req.subindex <= 8'(OUTPUT_COUNT));

  // RULE1 two-level key lookup
  always_comb begin
    info = '{present: 1'b0, writable: 1'b0, dtype: DT_U32, value: 32'h00000000};
    // RULE3 fixed identity entries
    if (isIdent) begin
      if (req.index == IDX_DEVTYPE && req.subindex == 8'h00) begin
        info = '{present: 1'b1, writable: 1'b0, dtype: DT_U32, value: DEVTYPE_VALUE};
      end else if (req.index == IDX_NAME && req.subindex == 8'h00) begin
        info = '{present: 1'b1, writable: 1'b0, dtype: DT_STRING, value: NAME_VALUE};
      end else if (req.index == IDX_IDENTITY) begin
        case (req.subindex)
          8'h00: info = '{1'b1, 1'b0, DT_U8, {24'h000000, IDENTITY_SUBCOUNT}};
          8'h01: info = '{1'b1, 1'b0, DT_U32, VENDOR_VALUE};
          8'h02: info = '{1'b1, 1'b0, DT_U32, PRODUCT_VALUE};
          8'h03: info = '{1'b1, 1'b0, DT_U32, REVISION_VALUE};
          8'h04: info = '{1'b1, 1'b0, DT_U32, SERIAL_VALUE};
          default: info = '{1'b0, 1'b0, DT_U32, 32'h00000000};
        endcase
      end else if (req.index == IDX_PDO_CUR && req.subindex == 8'h00) begin
        info = '{present: 1'b1, writable: 1'b0, dtype: DT_U32, value: PDO_CUR_VALUE};
      end else if (req.index == IDX_PDO_AVAIL && req.subindex == 8'h00) begin
        info = '{present: 1'b1, writable: 1'b0, dtype: DT_U32, value: PDO_AVAIL_VALUE};
      end
    end else if (chanHit) begin
      // RULE4 variable channel entries
      info = '{1'b1, 1'b1, DT_U32, chanMem[chanNum][chanParam[1:0]]};
    end else if (isInput) begin
      // RULE6 input objects read-only
      if (subZero) begin
        info = '{1'b1, 1'b0, DT_U8, 32'(INPUT_COUNT)};
      end else if (inHit) begin
        info = '{1'b1, 1'b0, DT_U32, inputData[slot_of(req.subindex)]};
      end
    end else if (isOutput) begin
      // RULE7 output objects writable from subindex one; subindex zero read-only
      if (req.subindex == 8'h00) begin
        info = '{1'b1, 1'b0, DT_U8, 32'(OUTPUT_COUNT)};
      end else if (outHit) begin
        info = '{1'b1, 1'b1, DT_U32, outputData_reg[outSel]};
      end
    end else if (isSuppress && req.subindex == 8'h00) begin
      info = '{present: 1'b1, writable: 1'b1, dtype: DT_U32, value: suppressWord_reg};
    end
  end

  // RULE8 size matches type
  assign sizeOk = req.size == type_size(info.dtype);
  // RULE2 only variable entries written
  assign doWrite = reqValid && req.write && info.present && info.writable && sizeOk;

  // RULE12 response with error codes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resp_reg <= '{code: RESP_OK, dtype: DT_BOOL, data: 32'h00000000};
      respValid_reg <= 1'b0;
    end else begin
      respValid_reg <= reqValid;
      if (reqValid) begin
        resp_reg.dtype <= info.dtype;
        // errors and writes answer with zero data
        resp_reg.data <= 32'h00000000;
        if (!info.present) begin
          resp_reg.code <= RESP_NO_OBJECT;
        end else if (req.write && !info.writable) begin
          resp_reg.code <= RESP_READ_ONLY;
        end else if (req.write && !sizeOk) begin
          resp_reg.code <= RESP_SIZE;
        end else begin
          resp_reg.code <= RESP_OK;
          // RULE9 reads always granted
          if (!req.write) begin
            resp_reg.data <= info.value;
          end
        end
      end
    end
  end

  // RULE10 per-channel parameter store
  genvar c;
  genvar p;
  generate
    for (c = 0; c < CHAN_COUNT; c++) begin : gen_chan
      for (p = 0; p < CHAN_PARAMS; p++) begin : gen_param
        always_ff @(posedge mclk or negedge arst_n) begin
          if (!arst_n) begin
            chanMem[c][p] <= CHAN_PARAM_RESET;
          end else if (doWrite && chanHit && chanNum == 2'(c) && chanParam[1:0] == 2'(p)) begin
            chanMem[c][p] <= req.data;
          end
        end
      end
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < OUTPUT_COUNT; g++) begin : gen_out
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          outputData_reg[g] <= OUTPUT_RESET;
        end else if (doWrite && outHit && outSel == 2'(g)) begin
          outputData_reg[g] <= req.data;
        end
      end
    end
  endgenerate

  // RULE11 suppression code word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      suppressWord_reg <= 32'h00000000;
      storeSuppress_reg <= 1'b0;
    end else if (doWrite && isSuppress) begin
      suppressWord_reg <= req.data;
      // any other word lifts the suppression
      storeSuppress_reg <= req.data == STORE_SUPPRESS_CODE;
    end
  end

  // RULE11 save request unless suppressed
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      saveStrobe_reg <= 1'b0;
      saveIndex_reg <= 16'h0000;
      saveSubindex_reg <= 8'h00;
    end else begin
      saveStrobe_reg <= doWrite && chanHit && !storeSuppress_reg;
      if (doWrite && chanHit) begin
        saveIndex_reg <= req.index;
        saveSubindex_reg <= req.subindex;
      end
    end
  end
endmodule // parameter_object_dictionary
`default_nettype wire

//--- bench/param_dict_properties.sv
// concurrent checks on the dictionary ports
`timescale 1ns/10ps
`default_nettype none
module param_dict_properties (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic altLayout,
  input wire logic reqValid,
  input wire param_dict_pkg::dict_req_t req,
  input wire param_dict_pkg::dict_resp_t resp_reg,
  input wire logic respValid_reg,
  input wire logic storeSuppress_reg,
  input wire logic saveStrobe_reg,
  input wire logic [15:0] saveIndex_reg
);
  import param_dict_pkg::*;
  logic [15:0] cb;
  logic wr;
  assign cb = altLayout ? IDX_ALT_CHAN_BASE : IDX_CHAN_BASE;
  assign wr = reqValid && req.write && req.subindex == 8'h00;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_resp_follows: assert property (reqValid |=> respValid_reg)
    else $error("no response");
  a_no_extra: assert property (!reqValid |=> !respValid_reg)
    else $error("stray response");
  a_fixed_refused: assert property (wr && req.index == IDX_NAME
    |=> resp_reg.code == RESP_READ_ONLY && resp_reg.data == 32'h00000000)
    else $error("fixed entry written");
  a_ident_read: assert property (reqValid && !req.write && req.index == IDX_IDENTITY
    && req.subindex == 8'h01 |=> resp_reg.code == RESP_OK && resp_reg.data == VENDOR_VALUE)
    else $error("identity word wrong");
  a_chan_save: assert property (wr && req.index == cb + 16'h0010 && req.size == 3'h4
    && !storeSuppress_reg |=> saveStrobe_reg && saveIndex_reg == $past(req.index))
    else $error("channel write not saved");
  a_size_refused: assert property (wr && req.index == cb && req.size == 3'h1
    |=> resp_reg.code == RESP_SIZE)
    else $error("size mismatch taken");
  a_missing_refused: assert property (reqValid && req.index == 16'h0000
    |=> resp_reg.code == RESP_NO_OBJECT && !saveStrobe_reg)
    else $error("missing entry answered");
  a_suppress_set: assert property (wr && req.index == IDX_STORE_SUPPRESS
    && req.data == STORE_SUPPRESS_CODE && req.size == 3'h4 |=> storeSuppress_reg)
    else $error("code word ignored");
  c_chan: cover property (wr && req.index == cb);
  c_supp: cover property (storeSuppress_reg && wr);
  c_size: cover property (respValid_reg && resp_reg.code == RESP_SIZE);
endmodule // param_dict_properties
bind parameter_object_dictionary param_dict_properties props (.mclk, .arst_n, .altLayout,
  .reqValid, .req, .resp_reg, .respValid_reg, .storeSuppress_reg, .saveStrobe_reg,
  .saveIndex_reg);
`default_nettype wire

//--- bench/fieldbus_master_model.sv
// request driver standing in for the fieldbus master
`timescale 1ns/10ps
`default_nettype none
module fieldbus_master_model (
  input wire logic mclk,
  output logic reqValid,
  output param_dict_pkg::dict_req_t req,
  input wire param_dict_pkg::dict_resp_t resp_reg,
  input wire logic respValid_reg
);
  import param_dict_pkg::*;
  logic ok;
  dict_resp_t got;
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [2:0] z, input logic [31:0] v);
    @(posedge mclk);
    #1 reqValid = 1'b1;
    req = '{write: w, index: i, subindex: s, size: z, data: v};
    @(posedge mclk);
    #1 reqValid = 1'b0;
    // idle lines carry no stale value
    req = ~req;
    ok = respValid_reg;
    got = resp_reg;
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

//--- bench/parameter_object_dictionary_tb.sv
// self-checking bench for the parameter object dictionary
`timescale 1ns/10ps
`default_nettype none
module parameter_object_dictionary_tb;
  import param_dict_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic altLayout = 1'b0;
  logic reqValid, respValid, supp, save;
  dict_req_t req;
  dict_resp_t resp;
  logic [15:0] sIdx;
  logic [7:0] sSub;
  logic [31:0] inData [INPUT_COUNT];
  logic [31:0] outData [OUTPUT_COUNT];
  logic [31:0] cm [16];
  logic [31:0] d;
  int mismatches = 0;
  int compares = 0;
  always #50 mclk = ~mclk;
  parameter_object_dictionary dut (.mclk, .arst_n, .altLayout, .reqValid, .req,
    .inputData(inData), .resp_reg(resp), .respValid_reg(respValid),
    .outputData_reg(outData), .storeSuppress_reg(supp), .saveStrobe_reg(save),
    .saveIndex_reg(sIdx), .saveSubindex_reg(sSub));
  fieldbus_master_model m (.mclk, .reqValid, .req, .resp_reg(resp), .respValid_reg(respValid));
  task automatic conclude();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic c);
    compares++;
    if (!c) begin
      mismatches++;
      $display("[FAIL] %0t wrong result", $time);
    end
  endtask
  task automatic tx(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] v, input resp_code_t c, input logic [31:0] x);
    m.access(w, i, s, 3'h4, v);
    chk(m.ok === 1'b1 && m.got.code === c && m.got.data === x);
  endtask
  function automatic logic [15:0] ci(input logic [15:0] b, input int k);
    return b + 16'(16 * (k / 4) + k % 4);
  endfunction
  initial begin
    void'($urandom(34598));
    foreach (inData[k]) inData[k] = $urandom;
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    tx(0, IDX_DEVTYPE, 0, 0, RESP_OK, DEVTYPE_VALUE);
    tx(1, IDX_NAME, 0, 1, RESP_READ_ONLY, 0);
    tx(0, IDX_NAME, 0, 0, RESP_OK, NAME_VALUE);
    chk(m.got.dtype === DT_STRING);
    tx(0, IDX_IDENTITY, 0, 0, RESP_OK, 32'(IDENTITY_SUBCOUNT));
    chk(m.got.dtype === DT_U8);
    tx(0, IDX_IDENTITY, 8'h04, 0, RESP_OK, SERIAL_VALUE);
    tx(0, IDX_IDENTITY, 8'h05, 0, RESP_NO_OBJECT, 0);
    tx(0, IDX_PDO_CUR, 0, 0, RESP_OK, PDO_CUR_VALUE);
    tx(0, IDX_IDENTITY, 8'h01, 0, RESP_OK, VENDOR_VALUE);
    tx(0, IDX_PDO_AVAIL, 0, 0, RESP_OK, PDO_AVAIL_VALUE);
    for (int k = 0; k < 16; k++) begin
      cm[k] = $urandom;
      tx(1, ci(IDX_CHAN_BASE, k), 0, cm[k], RESP_OK, 0);
      chk(save === 1'b1 && sIdx === ci(IDX_CHAN_BASE, k) && sSub === 8'h00);
    end
    for (int k = 0; k < 16; k++) tx(0, ci(IDX_CHAN_BASE, k), 0, 0, RESP_OK, cm[k]);
    m.access(1, IDX_CHAN_BASE, 0, 3'h1, 32'h0000005A);
    chk(m.got.code === RESP_SIZE);
    tx(1, IDX_CHAN_BASE + 16'h0004, 0, 0, RESP_NO_OBJECT, 0);
    tx(0, IDX_CHAN_BASE, 8'h01, 0, RESP_NO_OBJECT, 0);
    tx(1, 16'hFFFF, 8'hFF, 0, RESP_NO_OBJECT, 0);
    tx(0, 16'h0000, 0, 0, RESP_NO_OBJECT, 0);
    tx(0, IDX_CHAN_BASE, 0, 0, RESP_OK, cm[0]);
    chk(m.got.dtype === DT_U32);
    tx(0, IDX_INPUT_BASE, 0, 0, RESP_OK, 32'(INPUT_COUNT));
    tx(0, IDX_OUTPUT_BASE, 8'h05, 0, RESP_NO_OBJECT, 0);
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      tx(0, IDX_INPUT_BASE, 8'(k + 1), 0, RESP_OK, inData[k]);
      tx(1, IDX_INPUT_BASE, 8'(k + 1), d, RESP_READ_ONLY, 0);
      tx(1, IDX_OUTPUT_BASE, 8'(k + 1), d, RESP_OK, 0);
      chk(outData[k] === d && save === 1'b0);
    end
    tx(0, IDX_OUTPUT_BASE, 8'h04, 0, RESP_OK, d);
    tx(1, IDX_STORE_SUPPRESS, 0, STORE_SUPPRESS_CODE, RESP_OK, 0);
    chk(supp === 1'b1);
    tx(0, IDX_STORE_SUPPRESS, 0, 0, RESP_OK, STORE_SUPPRESS_CODE);
    tx(1, IDX_CHAN_BASE, 0, d, RESP_OK, 0);
    chk(save === 1'b0);
    tx(1, IDX_STORE_SUPPRESS, 0, ~STORE_SUPPRESS_CODE, RESP_OK, 0);
    chk(supp === 1'b0);
    tx(1, IDX_STORE_SUPPRESS, 0, STORE_SUPPRESS_CODE, RESP_OK, 0);
    arst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    chk(supp === 1'b0);
    tx(0, IDX_CHAN_BASE, 0, 0, RESP_OK, CHAN_PARAM_RESET);
    altLayout = 1'b1;
    tx(1, ci(IDX_ALT_CHAN_BASE, 9), 0, d, RESP_OK, 0);
    chk(save === 1'b1 && sIdx === ci(IDX_ALT_CHAN_BASE, 9));
    tx(0, ci(IDX_ALT_CHAN_BASE, 9), 0, 0, RESP_OK, d);
    tx(0, IDX_CHAN_BASE, 0, 0, RESP_NO_OBJECT, 0);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    conclude();
  end
endmodule // parameter_object_dictionary_tb
`default_nettype wire
